/* logic/drive_pin_defs.svh */
`ifndef DRIVE_PIN_DEFS_SVH
`define DRIVE_PIN_DEFS_SVH
// Summary of operation
// R1: one active-low motor enable per drive bit
// R2: pump select on: pin shows pump correction
// R3: pump select off: pin input sets precomp
// R4: pin as pump output: precomp mode reads high
// R5: host read request is strobe held low
// R6: reset idles controller, disables drive outputs
// R7: reset clears drive control to zero
// R8: reset loads data rate for 250 kb/s
// R9: specify parameters survive reset untouched
// R10: reset returns mode settings to defaults
// R11: hold reset asserted through power-up
// R12: strap low: speed low 250/300, high 500
// R13: strap high: output high at 500 kb/s
// R14: seek emits active-low step pulses, software rate
// R15: terminal count counts only with acknowledge active
// R16: reset clears pump select, pin is input

// drive control reset value and data rate codes
`define DRV_CTRL_RST  8'h00
`define RATE_500K     2'h0
`define RATE_300K     2'h1
`define RATE_250K     2'h2
`define RATE_1M       2'h3
`define RATE_RST      2'h2
// mode defaults
`define PUMP_SEL_RST  1'b0
// step pulse width in core cycles and rate unit (1 ms tick at 200 MHz)
`define STEP_PW_NS    1000
`define CLK_NS        5
`define STEP_PW_CYC   (`STEP_PW_NS / `CLK_NS)
`define TICK_CYC      200000
`define SRT_RST       4'h0
`endif

/* logic/drive_pin_pkg.sv */
package drive_pin_pkg;
    // pin-side bundle toward the drives
    typedef struct packed {
        logic [3:0] motor_en_n;   // active-low motor enables
        logic       step_n;       // active-low step
        logic       speed;        // speed or low current
    } drive_out_t;
    // seek engine states
    typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_WAIT} seek_state_t;
endpackage

/* logic/sync2.sv */
module sync2 (
    input  wire logic core_clk,  // core clock
    input  wire logic rst_n,     // async reset, active low
    input  wire logic d,         // asynchronous input
    output logic      q          // synchronised output
);
    logic meta_reg;               // first stage, read only by second
    // two-stage synchroniser
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

/* logic/fdc_drive_pin_control.sv */
`include "drive_pin_defs.svh"
module fdc_drive_pin_control
    import drive_pin_pkg::*;
(
    input  wire logic       core_clk,          // 200 MHz core clock
    input  wire logic       rst_n,             // async reset, active low
    input  wire logic       ctrl_reset,        // active-high controller reset pin
    input  wire logic       drv_ctrl_we,       // write strobe for drive control
    input  wire logic [7:0] drv_ctrl_wdata,    // drive control data, bits 7:4 motors
    input  wire logic       rate_we,           // write strobe for data rate
    input  wire logic [1:0] rate_wdata,        // data rate code
    input  wire logic       mode_we,           // mode command write
    input  wire logic       pump_indicator_wdata, // new pump select bit
    input  wire logic       specify_we,        // specify command write
    input  wire logic [3:0] step_rate_wdata,   // step interval in ticks minus one
    input  wire logic       seek_start,        // one-cycle seek request
    input  wire logic [7:0] seek_steps,        // tracks to move
    input  wire logic       pump_active,       // charge pump correcting
    input  wire logic       precomp_mode_in,   // pin level in input role
    input  wire logic       drive_type_strap,  // drive type strap pin
    input  wire logic       rd_n,              // host read strobe, active low
    input  wire logic       dma_ack_n,         // dma acknowledge, active low
    input  wire logic       dma_terminal_count,// terminal count, active high
    output drive_out_t      drv_out,           // motor, step, speed pins
    output logic            pump_or_precomp_pin,    // pump output value
    output logic            pump_or_precomp_oe_n,   // low while driving pump
    output logic            precomp_mode,      // effective precomp select
    output logic            pump_indicator_sel,// mode bit state
    output logic            host_read_req,     // synchronised read request
    output logic            tc_event,          // qualified terminal count, high while tc and ack both active
    output logic            seek_busy,         // seek in progress
    output logic [7:0]      drv_ctrl_q,        // drive control readback
    output logic [1:0]      rate_q             // data rate readback
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // read strobe and acknowledge are inverted before syncing, so both are active high
    logic reset_s, prec_s, strap_s, rd_req_s, ack_s, tc_s, pump_s;
    sync2 u_s0 (.core_clk(core_clk), .rst_n(rst_n), .d(ctrl_reset),         .q(reset_s));
    sync2 u_s1 (.core_clk(core_clk), .rst_n(rst_n), .d(precomp_mode_in),    .q(prec_s));
    sync2 u_s2 (.core_clk(core_clk), .rst_n(rst_n), .d(drive_type_strap),   .q(strap_s));
    sync2 u_s3 (.core_clk(core_clk), .rst_n(rst_n), .d(~rd_n),              .q(rd_req_s));
    sync2 u_s4 (.core_clk(core_clk), .rst_n(rst_n), .d(~dma_ack_n),         .q(ack_s));
    sync2 u_s5 (.core_clk(core_clk), .rst_n(rst_n), .d(dma_terminal_count), .q(tc_s));
    sync2 u_s6 (.core_clk(core_clk), .rst_n(rst_n), .d(pump_active),        .q(pump_s));

    // ------------------------------------------------------------
    // helper: rate decode, used for speed pin
    // ------------------------------------------------------------
    function automatic logic is_500k(input logic [1:0] r);
        is_500k = (r == `RATE_500K);
    endfunction

    // ------------------------------------------------------------
    // drive control register
    // ------------------------------------------------------------
    logic [7:0] drv_ctrl_reg;    // motors in bits 7:4
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drv_ctrl_reg <= `DRV_CTRL_RST;
        end else if (reset_s) begin
            drv_ctrl_reg <= `DRV_CTRL_RST; // R7
        end else if (drv_ctrl_we) begin
            drv_ctrl_reg <= drv_ctrl_wdata;
        end
    end

    // ------------------------------------------------------------
    // data rate register
    // ------------------------------------------------------------
    logic [1:0] rate_reg;        // current rate code
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_reg <= `RATE_RST;
        end else if (reset_s) begin
            rate_reg <= `RATE_RST; // R8
        end else if (rate_we) begin
            rate_reg <= rate_wdata;
        end
    end

    // ------------------------------------------------------------
    // mode and specify settings
    // ------------------------------------------------------------
    logic       pump_sel_reg;    // pump indicator select
    logic [3:0] srt_reg;         // step rate, kept across pin reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pump_sel_reg <= `PUMP_SEL_RST;
        end else if (reset_s) begin
            pump_sel_reg <= `PUMP_SEL_RST; // R10 R16
        end else if (mode_we) begin
            pump_sel_reg <= pump_indicator_wdata;
        end
    end
    // specify values ignore the controller reset pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            srt_reg <= `SRT_RST;
        end else if (specify_we) begin
            srt_reg <= step_rate_wdata; // R9
        end
    end

    // ------------------------------------------------------------
    // step rate tick divider
    // ------------------------------------------------------------
    logic [17:0] tick_cnt_reg;   // free-running tick divider
    logic        tick;           // one-cycle tick enable
    assign tick = (tick_cnt_reg == 18'(`TICK_CYC - 1));
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= 18'h0;
        end else begin
            tick_cnt_reg <= tick ? 18'h0 : tick_cnt_reg + 18'h1;
        end
    end

    // ------------------------------------------------------------
    // seek engine
    // ------------------------------------------------------------
    seek_state_t state_reg;      // seek state
    logic [7:0]  left_reg;       // steps remaining
    logic [7:0]  pw_reg;         // pulse width counter
    logic [3:0]  gap_reg;        // ticks left before next step, minus one
    logic        step_n_reg;     // step pin, active low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= ST_IDLE;
            left_reg   <= 8'h0;
            pw_reg     <= 8'h0;
            gap_reg    <= 4'h0;
            step_n_reg <= 1'b1;
        end else if (reset_s) begin
            // abort seek, step released
            state_reg  <= ST_IDLE; // R6
            step_n_reg <= 1'b1;
            left_reg   <= 8'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (seek_start && seek_steps != 8'h0) begin
                        left_reg   <= seek_steps;
                        pw_reg     <= 8'(`STEP_PW_CYC - 1);
                        step_n_reg <= 1'b0; // R14
                        state_reg  <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (pw_reg == 8'h0) begin
                        step_n_reg <= 1'b1;
                        left_reg   <= left_reg - 8'h1;
                        gap_reg    <= srt_reg;
                        state_reg  <= (left_reg == 8'h1) ? ST_IDLE : ST_WAIT;
                    end else begin
                        pw_reg <= pw_reg - 8'h1;
                    end
                end
                ST_WAIT: begin
                    // spacing in software-set ticks
                    if (tick) begin
                        if (gap_reg == 4'h0) begin
                            pw_reg     <= 8'(`STEP_PW_CYC - 1);
                            step_n_reg <= 1'b0; // R14
                            state_reg  <= ST_PULSE;
                        end else begin
                            gap_reg <= gap_reg - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drv_out              <= '{motor_en_n: 4'hf, step_n: 1'b1, speed: 1'b0};
            pump_or_precomp_pin  <= 1'b0;
            pump_or_precomp_oe_n <= 1'b1;
            precomp_mode         <= 1'b0;
            pump_indicator_sel   <= 1'b0;
            host_read_req        <= 1'b0;
            tc_event             <= 1'b0;
            seek_busy            <= 1'b0;
            drv_ctrl_q           <= `DRV_CTRL_RST;
            rate_q               <= `RATE_RST;
        end else begin
            // motor bit n drives its pin low when set
            drv_out.motor_en_n   <= reset_s ? 4'hf : ~drv_ctrl_reg[7:4]; // R1 R6
            drv_out.step_n       <= step_n_reg | reset_s; // R6
            // strap low: rpm select; strap high: low current; same level both ways
            drv_out.speed        <= is_500k(rate_reg); // R12 R13
            pump_or_precomp_pin  <= pump_s; // R2
            pump_or_precomp_oe_n <= ~pump_sel_reg; // R2 R3
            precomp_mode         <= pump_sel_reg ? 1'b1 : prec_s; // R3 R4
            pump_indicator_sel   <= pump_sel_reg;
            host_read_req        <= rd_req_s; // R5
            tc_event             <= tc_s & ack_s; // R15
            seek_busy            <= (state_reg != ST_IDLE);
            drv_ctrl_q           <= drv_ctrl_reg;
            rate_q               <= rate_reg;
        end
    end

    // strap is sampled for readers; unused beyond documentation of role
    logic strap_unused;
    assign strap_unused = strap_s;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_MOTOR: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
        !reset_s |=> drv_out.motor_en_n == ~$past(drv_ctrl_reg[7:4]))
        else $error("motor pins do not follow drive control");
    AST_PUMP_OE: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
        pump_sel_reg |=> !pump_or_precomp_oe_n)
        else $error("pump pin not driven when selected");
    AST_PREC_IN: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
        !pump_sel_reg |=> precomp_mode == $past(prec_s) && pump_or_precomp_oe_n)
        else $error("precomp not taken from pin");
    AST_PREC_HI: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
        pump_sel_reg |=> precomp_mode)
        else $error("precomp not forced high");
    AST_RST_OUT: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
        reset_s |=> drv_out.motor_en_n == 4'hf && drv_out.step_n)
        else $error("drive outputs active during reset");
    AST_DRV_CLR: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
        reset_s |=> drv_ctrl_reg == `DRV_CTRL_RST)
        else $error("drive control not cleared");
    AST_RATE_RST: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
        reset_s |=> rate_reg == `RATE_RST)
        else $error("rate not set to 250k");
    AST_SRT_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
        reset_s && !specify_we |=> srt_reg == $past(srt_reg))
        else $error("specify value lost at reset");
    AST_SPEED: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
        1'b1 |=> drv_out.speed == ($past(rate_reg) == `RATE_500K))
        else $error("speed pin wrong for rate");
    AST_STEP_W: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
        $fell(step_n_reg) && !reset_s |=> !step_n_reg [*8])
        else $error("step pulse too short");
    AST_TC: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
        tc_event |-> $past(ack_s) && $past(tc_s))
        else $error("terminal count without acknowledge");
    AST_MODE_RST: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
        reset_s |=> !pump_sel_reg ##1 pump_or_precomp_oe_n)
        else $error("pump select not cleared");
endmodule

/* dv/drive_far_side.sv */
module drive_far_side (
    input  wire logic        core_clk,     // core clock
    input  wire logic        rst_n,        // async reset, active low
    input  wire logic        pin_out,      // pump value from the block
    input  wire logic        pin_oe_n,     // low while the block drives the pin
    input  wire logic        ext_level,    // level the board puts on the pin
    input  wire logic        step_n,       // step line toward the drive
    output logic             pin_level,    // resolved level of the shared pin
    output logic [7:0]       step_pulses,  // pulses seen by the drive
    output logic [15:0]      step_width    // low cycles of the last pulse
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] low_cnt_reg;              // running low-time count

    // ----------------------------------------
    // shared pin: block wins only while driving
    // ----------------------------------------
    assign pin_level = pin_oe_n ? ext_level : pin_out;

    // ----------------------------------------
    // head mechanism: one track per pulse
    // ----------------------------------------
    // width is taken at the rising edge so a pulse cut by reset still counts
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_reg <= 16'h0000;
            step_pulses <= 8'h00;
            step_width  <= 16'h0000;
        end else if (!step_n) begin
            low_cnt_reg <= low_cnt_reg + 16'h0001;
        end else if (low_cnt_reg != 16'h0000) begin
            step_pulses <= step_pulses + 8'h01;
            step_width  <= low_cnt_reg;
            low_cnt_reg <= 16'h0000;
        end
    end
endmodule

/* dv/test_fdc_drive_pin_control.sv */
`include "drive_pin_defs.svh"
module test_fdc_drive_pin_control;
    timeunit 1ns;
    timeprecision 1ps;
    import drive_pin_pkg::*;

    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic core_clk = 1'b0;                 // 200 MHz
    logic rst_n, ctrl_reset;               // resets
    logic drv_ctrl_we, rate_we, mode_we, specify_we, seek_start; // strobes
    logic [7:0] drv_ctrl_wdata, seek_steps; // write data
    logic [1:0] rate_wdata;                // data rate code
    logic [3:0] step_rate_wdata;           // step interval
    logic pump_indicator_wdata, pump_active, ext_level, pin_level; // shared pin
    logic drive_type_strap, rd_n, dma_ack_n, dma_terminal_count; // async levels
    drive_out_t drv_out;                   // drive pins
    logic pin_out, pin_oe_n, precomp_mode, pump_sel, host_read_req; // outputs
    logic tc_event, seek_busy;             // outputs
    logic [7:0] drv_ctrl_q, step_pulses;   // readback, pulse count
    logic [1:0] rate_q;                    // rate readback
    logic [15:0] step_width;               // last pulse width
    int mismatches = 0;                    // failed compares
    int samples_checked = 0;               // all compares

    always #2.5 core_clk = ~core_clk;

    fdc_drive_pin_control fdc_drive_pin_control_i (
        .core_clk(core_clk), .rst_n(rst_n), .ctrl_reset(ctrl_reset),
        .drv_ctrl_we(drv_ctrl_we), .drv_ctrl_wdata(drv_ctrl_wdata),
        .rate_we(rate_we), .rate_wdata(rate_wdata), .mode_we(mode_we),
        .pump_indicator_wdata(pump_indicator_wdata), .specify_we(specify_we),
        .step_rate_wdata(step_rate_wdata), .seek_start(seek_start),
        .seek_steps(seek_steps), .pump_active(pump_active),
        .precomp_mode_in(pin_level), .drive_type_strap(drive_type_strap),
        .rd_n(rd_n), .dma_ack_n(dma_ack_n), .dma_terminal_count(dma_terminal_count),
        .drv_out(drv_out), .pump_or_precomp_pin(pin_out),
        .pump_or_precomp_oe_n(pin_oe_n), .precomp_mode(precomp_mode),
        .pump_indicator_sel(pump_sel), .host_read_req(host_read_req),
        .tc_event(tc_event), .seek_busy(seek_busy), .drv_ctrl_q(drv_ctrl_q),
        .rate_q(rate_q));

    drive_far_side drive_far_side_i (
        .core_clk(core_clk), .rst_n(rst_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_level(ext_level), .step_n(drv_out.step_n), .pin_level(pin_level),
        .step_pulses(step_pulses), .step_width(step_width));

    // ----------------------------------------
    // access tasks and compare
    // ----------------------------------------
    // which: 0 drive control, 1 rate, 2 mode, 3 specify; strobe lasts one cycle
    task automatic wr(input int which, input logic [7:0] d);
        @(negedge core_clk);
        drv_ctrl_we = (which == 0);
        rate_we = (which == 1);
        mode_we = (which == 2);
        specify_we = (which == 3);
        drv_ctrl_wdata = d;
        rate_wdata = d[1:0];
        pump_indicator_wdata = d[0];
        step_rate_wdata = d[3:0];
        @(negedge core_clk);
        {drv_ctrl_we, rate_we, mode_we, specify_we} = 4'h0;
        repeat (4) @(negedge core_clk);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic settle();
        repeat (5) @(negedge core_clk); // async inputs need three edges
    endtask

    task automatic close_out();
        $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // watchdog: whole sequence takes about 370 cycles
    // ----------------------------------------
    initial begin
        #(5 * 20000);
        mismatches++;
        close_out();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        // controller reset pin held through power-up
        {ctrl_reset, drv_ctrl_we, rate_we, mode_we, specify_we, seek_start} = 6'h20;
        {drv_ctrl_wdata, seek_steps, rate_wdata, step_rate_wdata} = 22'h000000;
        {pump_indicator_wdata, pump_active, ext_level, drive_type_strap} = 4'h0;
        {rd_n, dma_ack_n, dma_terminal_count} = 3'b110;
        rst_n = 1'b0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        chk(drv_out.motor_en_n, 16'h000f);
        chk(drv_ctrl_q, `DRV_CTRL_RST);
        chk(rate_q, `RATE_RST);
        chk(pump_sel, `PUMP_SEL_RST);
        chk({pin_oe_n, drv_out.step_n}, 16'h0003);
        // let go of the pin reset only once the core reset is over
        ctrl_reset = 1'b0;
        settle();
        // each motor alone, then a pair
        for (int i = 0; i < 5; i++) begin
            wr(0, (i < 4) ? (8'h10 << i) : 8'h50);
            chk(drv_out.motor_en_n, {12'h000, ~drv_ctrl_wdata[7:4]});
            chk(drv_ctrl_q, drv_ctrl_wdata);
        end
        // every rate code under both strap levels
        for (int s = 0; s < 2; s++) begin
            for (int r = 0; r < 4; r++) begin
                drive_type_strap = s[0];
                wr(1, 8'(r));
                chk(drv_out.speed, 16'(r == `RATE_500K));
            end
        end
        for (int v = 0; v < 2; v++) begin
            ext_level = v[0];
            settle();
            chk({pin_oe_n, precomp_mode}, {15'h0001, v[0]});
        end
        wr(2, 8'h01);
        ext_level = 1'b0;
        chk({pump_sel, pin_oe_n}, 16'h0002);
        for (int v = 0; v < 2; v++) begin
            pump_active = v[0];
            settle();
            chk(pin_level, 16'(v));
            chk(precomp_mode, 16'h0001);
        end
        rd_n = 1'b0;
        settle();
        chk(host_read_req, 16'h0001);
        rd_n = 1'b1;
        dma_terminal_count = 1'b1;
        settle();
        chk({host_read_req, tc_event}, 16'h0000);
        dma_ack_n = 1'b0;
        settle();
        chk(tc_event, 16'h0001);
        {dma_terminal_count, dma_ack_n} = 2'b01;
        // zero steps must not start a seek
        wr(3, 8'h00);
        seek_start = 1'b1;
        @(negedge core_clk);
        seek_start = 1'b0;
        settle();
        chk(seek_busy, 16'h0000);
        seek_steps = 8'h02;
        seek_start = 1'b1;
        @(negedge core_clk);
        seek_start = 1'b0;
        for (int n = 0; n < 400 && step_pulses == 8'h00; n++) @(negedge core_clk);
        chk(step_width, `STEP_PW_CYC);
        chk({seek_busy, step_pulses}, 16'h0101);
        // controller reset mid-seek; a write during it is refused
        ctrl_reset = 1'b1;
        // wait out the synchroniser so the write meets an active reset
        settle();
        wr(0, 8'hf0);
        chk(drv_out.motor_en_n, 16'h000f);
        chk(drv_ctrl_q, `DRV_CTRL_RST);
        chk(rate_q, `RATE_RST);
        chk({pump_sel, pin_oe_n}, 16'h0001);
        chk({seek_busy, drv_out.step_n}, 16'h0001);
        ctrl_reset = 1'b0;
        settle();
        wr(0, 8'h30);
        chk(drv_out.motor_en_n, 16'h000c);
        close_out();
    end
endmodule
